// ---- src/backplane_bus_control.sv ----
// Backplane master bus control, bus-error timer, reset, clocks and acquisition lines
// Summary of operation
// - Processor side alone drives address and strobe lines; slaves drive data on reads.
// - Address strobe frames every sixteen-bit transfer; slaves qualify on it.
// - Upper byte strobe enables the high data byte.
// - Lower byte strobe enables the low data byte.
// - Direction line high for reads, low for writes; slaves drive only reads.
// - Bus error asserted if no acknowledge within 50 us of cycle start.
// - Reset line low 200 ms after supply good, and whenever supply lost.
// - Processor clocks 16, 8, 4, 2 MHz by successive halving.
// - Acquisition master clock with 50 percent duty cycle.
// - Two synchronous trigger lines carry the same trigger function.
// - Two sample-rate memory clocks, one per converter board.
// - Two conversion gates; converters convert only while gated.
// - Trigger enable line gates trigger response.
// - Bus request and grant held fixed so the processor always owns the bus.
// - Data bus sixteen bits, bit fifteen most significant.
`timescale 1ns/1ps
module backplane_bus_control #(
  parameter int POR_CYCLES  = backplane_pkg::POR_CYCLES,
  parameter int BERR_CYCLES = backplane_pkg::BERR_CYCLES,
  parameter int ACQ_DIV     = backplane_pkg::ACQ_DIV_DEFAULT,
  parameter int SMCLK_DIV   = backplane_pkg::SMCLK_DIV_DEFAULT
) (
  input  wire logic                              clk,                 // System clock
  input  wire logic                              rstn,                // Async reset, active low
  input  wire logic                              supply_good,         // 5 V above 4.5 V, async
  input  wire logic                              clock_src,           // 16 MHz source pin, async
  input  wire logic                              cpu_req,             // Start a bus cycle
  input  wire logic                              cpu_rnw,             // 1 read, 0 write
  input  wire logic [1:0]                        cpu_byte_en,         // [1] upper, [0] lower
  input  wire logic [backplane_pkg::ADDR_W-1:0]  cpu_addr,            // Word address
  input  wire logic [backplane_pkg::DATA_W-1:0]  cpu_wdata,           // Write data
  output logic                                   cpu_busy,            // Cycle in progress
  output logic                                   cpu_done,            // Cycle ended pulse
  output logic                                   cpu_berr,            // Ended by bus error
  output logic [backplane_pkg::DATA_W-1:0]       cpu_rdata,           // Read data
  output logic [backplane_pkg::ADDR_W-1:0]       address,             // Backplane address
  output logic [backplane_pkg::DATA_W-1:0]       data_out,            // Backplane data out
  output logic                                   data_oe,             // Drives data lines
  input  wire logic [backplane_pkg::DATA_W-1:0]  data_in,             // Backplane data in
  output logic                                   address_strobe_n,    // Address strobe
  output logic                                   upper_byte_strobe_n, // High byte strobe
  output logic                                   lower_byte_strobe_n, // Low byte strobe
  output logic                                   read_not_write,      // Direction
  input  wire logic                              transfer_ack_n,      // Open-collector ack, async
  output logic                                   bus_error_n,         // Bus error to processor
  output logic                                   power_on_reset_n,    // Reset line
  output logic                                   bus_request_n,       // Fixed, no request
  output logic                                   bus_grant_n,         // Fixed, granted
  output logic [3:0]                             proc_clocks,         // 16,8,4,2 MHz
  input  wire logic                              acq_run,             // Acquisition running
  input  wire logic                              gate_req_a,          // Convert request, board a
  input  wire logic                              gate_req_b,          // Convert request, board b
  input  wire logic                              trigger_event,       // Trigger from same clock
  output logic                                   acq_master_clock,    // Acquisition master clock
  output logic                                   sync_trigger_a,      // Synchronous trigger
  output logic                                   sync_trigger_b,      // Same function
  output logic                                   sample_mem_clock_a,  // Sample memory clock a
  output logic                                   sample_mem_clock_b,  // Sample memory clock b
  output logic                                   convert_gate_a,      // Gate a
  output logic                                   convert_gate_b,      // Gate b
  output logic                                   trigger_enable_line  // Trigger enable
);
  localparam int            TW        = backplane_pkg::TIMER_W;
  localparam logic [TW-1:0] BERR_LAST = TW'(BERR_CYCLES - 1);
  localparam logic [TW-1:0] POR_LAST  = TW'(POR_CYCLES - 1);
  localparam logic [TW-1:0] ACQ_LAST  = TW'(ACQ_DIV - 1);
  localparam logic [TW-1:0] SM_LAST   = TW'(SMCLK_DIV - 1);
  // Synchronisers for pins from outside the clock domain
  logic [1:0] ack_sync_reg, sup_sync_reg, src_sync_reg;
  logic       src_prev_reg;
  // Read data crosses with the same two stages as the acknowledge that qualifies it
  logic [backplane_pkg::DATA_W-1:0] din_sync_reg [2];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_sync_reg <= 2'h3;
      sup_sync_reg <= 2'h0;
      src_sync_reg <= 2'h0;
      src_prev_reg <= 1'b0;
      din_sync_reg <= '{default: '0};
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], transfer_ack_n};
      sup_sync_reg <= {sup_sync_reg[0], supply_good};
      src_sync_reg <= {src_sync_reg[0], clock_src};
      src_prev_reg <= src_sync_reg[1];
      din_sync_reg <= '{data_in, din_sync_reg[0]};
    end
  end
  wire ack_seen = ~ack_sync_reg[1];
  assign bus_request_n = 1'b1;
  assign bus_grant_n   = 1'b0;

  // Bus cycle state
  backplane_pkg::bus_state_t state_reg, state_next;
  logic [backplane_pkg::TIMER_W-1:0] berr_cnt_reg, berr_cnt_next;
  logic [backplane_pkg::ADDR_W-1:0]  addr_reg, addr_next;
  logic [backplane_pkg::DATA_W-1:0]  wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [1:0] be_reg, be_next;
  logic rnw_reg, rnw_next, berr_reg, berr_next, done_reg, done_next, fail_reg, fail_next;

  always_comb begin
    state_next    = state_reg;
    berr_cnt_next = berr_cnt_reg;
    addr_next     = addr_reg;
    wdata_next    = wdata_reg;
    rdata_next    = rdata_reg;
    be_next       = be_reg;
    rnw_next      = rnw_reg;
    berr_next     = berr_reg;
    done_next     = 1'b0;
    fail_next     = fail_reg;
    unique case (state_reg)
      backplane_pkg::ST_IDLE: begin
        if (cpu_req && power_on_reset_n) begin
          addr_next     = cpu_addr;
          wdata_next    = cpu_wdata;
          be_next       = cpu_byte_en;
          rnw_next      = cpu_rnw;
          berr_cnt_next = backplane_pkg::TIMER_RESET;
          state_next    = backplane_pkg::ST_STROB;
        end
      end
      // Address, direction and strobes all take effect on the same edge
      backplane_pkg::ST_STROB: state_next = backplane_pkg::ST_WAIT;
      backplane_pkg::ST_WAIT: begin
        berr_cnt_next = berr_cnt_reg + 1'b1;
        if (ack_seen) begin
          if (rnw_reg) rdata_next = din_sync_reg[1];
          fail_next  = 1'b0;
          done_next  = 1'b1;
          state_next = backplane_pkg::ST_END;
        end else if (berr_cnt_reg >= BERR_LAST - 24'h000002) begin
          berr_next  = 1'b1;
          fail_next  = 1'b1;
          done_next  = 1'b1;
          state_next = backplane_pkg::ST_END;
        end
      end
      backplane_pkg::ST_END: begin
        // wait for slave to release acknowledge after strobe negates
        if (!ack_seen) begin
          berr_next  = 1'b0;
          state_next = backplane_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= backplane_pkg::ST_IDLE;
      berr_cnt_reg <= backplane_pkg::TIMER_RESET;
      addr_reg     <= '0;
      wdata_reg    <= '0;
      rdata_reg    <= '0;
      be_reg       <= 2'h0;
      rnw_reg      <= 1'b1;
      berr_reg     <= 1'b0;
      done_reg     <= 1'b0;
      fail_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      berr_cnt_reg <= berr_cnt_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      rdata_reg    <= rdata_next;
      be_reg       <= be_next;
      rnw_reg      <= rnw_next;
      berr_reg     <= berr_next;
      done_reg     <= done_next;
      fail_reg     <= fail_next;
    end
  end

  wire strobing = (state_reg == backplane_pkg::ST_STROB) ||
                  (state_reg == backplane_pkg::ST_WAIT);
  assign address_strobe_n    = ~strobing;
  assign upper_byte_strobe_n = ~(strobing && be_reg[1]);
  assign lower_byte_strobe_n = ~(strobing && be_reg[0]);
  assign read_not_write = rnw_reg;
  assign data_oe        = strobing && !rnw_reg;
  assign data_out    = wdata_reg;
  assign address     = addr_reg;
  assign bus_error_n = ~berr_reg;
  assign cpu_busy    = (state_reg != backplane_pkg::ST_IDLE);
  assign cpu_done    = done_reg;
  assign cpu_berr    = fail_reg;
  assign cpu_rdata   = rdata_reg;
  // Power-on reset timer; a supply dip restarts the full hold
  logic [backplane_pkg::TIMER_W-1:0] por_cnt_reg, por_cnt_next;
  logic por_n_reg, por_n_next;
  always_comb begin
    por_cnt_next = por_cnt_reg;
    por_n_next   = por_n_reg;
    // hold then release, drop on supply loss
    if (!sup_sync_reg[1]) begin
      por_cnt_next = backplane_pkg::TIMER_RESET;
      por_n_next   = 1'b0;
    end else if (por_cnt_reg == POR_LAST) begin
      por_n_next = 1'b1;
    end else begin
      por_cnt_next = por_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt_reg <= backplane_pkg::TIMER_RESET;
      por_n_reg   <= 1'b0;
    end else begin
      por_cnt_reg <= por_cnt_next;
      por_n_reg   <= por_n_next;
    end
  end
  assign power_on_reset_n = por_n_reg;
  // Clock dividers and acquisition lines
  logic [backplane_pkg::PCLK_W-1:0] pclk_reg, pclk_next;
  logic [backplane_pkg::TIMER_W-1:0] acq_cnt_reg, acq_cnt_next, sm_cnt_reg, sm_cnt_next;
  logic acq_reg, acq_next, sm_reg, sm_next, trig_reg, trig_next;
  logic gate_a_reg, gate_a_next, gate_b_reg, gate_b_next, ten_reg, ten_next;
  always_comb begin
    // successive halving on each source rising edge
    pclk_next = pclk_reg;
    if (src_sync_reg[1] && !src_prev_reg) pclk_next = pclk_reg + 1'b1;
    acq_cnt_next = acq_cnt_reg + 1'b1;
    acq_next     = acq_reg;
    if (acq_cnt_reg == ACQ_LAST) begin
      acq_cnt_next = backplane_pkg::TIMER_RESET;
      acq_next     = ~acq_reg;
    end
    // sample clocks run only during acquisition
    sm_cnt_next = sm_cnt_reg + 1'b1;
    sm_next     = sm_reg;
    if (!acq_run) begin
      sm_cnt_next = backplane_pkg::TIMER_RESET;
      sm_next     = 1'b0;
    end else if (sm_cnt_reg == SM_LAST) begin
      sm_cnt_next = backplane_pkg::TIMER_RESET;
      sm_next     = ~sm_reg;
    end
    // gates follow requests only while running
    gate_a_next = acq_run && gate_req_a;
    gate_b_next = acq_run && gate_req_b;
    ten_next  = acq_run;
    trig_next = trigger_event && ten_reg;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pclk_reg    <= backplane_pkg::PCLK_RESET;
      acq_cnt_reg <= backplane_pkg::TIMER_RESET;
      sm_cnt_reg  <= backplane_pkg::TIMER_RESET;
      acq_reg     <= 1'b0;
      sm_reg      <= 1'b0;
      trig_reg    <= 1'b0;
      gate_a_reg  <= 1'b0;
      gate_b_reg  <= 1'b0;
      ten_reg     <= 1'b0;
    end else begin
      pclk_reg    <= pclk_next;
      acq_cnt_reg <= acq_cnt_next;
      sm_cnt_reg  <= sm_cnt_next;
      acq_reg     <= acq_next;
      sm_reg      <= sm_next;
      trig_reg    <= trig_next;
      gate_a_reg  <= gate_a_next;
      gate_b_reg  <= gate_b_next;
      ten_reg     <= ten_next;
    end
  end
  assign proc_clocks         = {pclk_reg[2], pclk_reg[1], pclk_reg[0], src_prev_reg};
  assign acq_master_clock    = acq_reg;
  assign sync_trigger_a      = trig_reg;
  assign sync_trigger_b      = trig_reg;
  assign sample_mem_clock_a  = sm_reg;
  assign sample_mem_clock_b  = sm_reg;
  assign convert_gate_a      = gate_a_reg;
  assign convert_gate_b      = gate_b_reg;
  assign trigger_enable_line = ten_reg;
endmodule

// ---- inc/backplane_pkg.sv ----
// Constants shared by the backplane bus control logic
package backplane_pkg;
  localparam int CLK_KHZ           = 10000;
  localparam int BERR_TIMEOUT_US   = 50;
  localparam int BERR_CYCLES       = BERR_TIMEOUT_US * CLK_KHZ / 1000;
  localparam int POR_HOLD_MS       = 200;
  localparam int POR_CYCLES        = POR_HOLD_MS * CLK_KHZ;
  localparam int DATA_W            = 16;
  localparam int ADDR_W            = 22;
  localparam int SLOT_ID_LSB       = 18;
  localparam int TIMER_W           = 24;
  localparam int PCLK_W            = 3;
  localparam int ACQ_DIV_DEFAULT   = 1;
  localparam int SMCLK_DIV_DEFAULT = 4;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 24'h000000;
  localparam logic [PCLK_W-1:0]  PCLK_RESET  = 3'h0;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_STROB = 2'b01,
    ST_WAIT  = 2'b10,
    ST_END   = 2'b11
  } bus_state_t;
endpackage

// ---- tb/bus_control_monitor.sv ----
// Port-level assertions for the backplane bus control block
`timescale 1ns/1ps
module bus_control_monitor #(
  parameter int BERR_CYCLES = 500
) (
  input wire logic clk,                 // Clock
  input wire logic rstn,                // Reset, active low
  input wire logic supply_good,         // Supply indication
  input wire logic cpu_done,            // Cycle end pulse
  input wire logic cpu_berr,            // Ended by error
  input wire logic data_oe,             // Data drive enable
  input wire logic address_strobe_n,    // Address strobe
  input wire logic upper_byte_strobe_n, // High byte strobe
  input wire logic lower_byte_strobe_n, // Low byte strobe
  input wire logic read_not_write,      // Direction
  input wire logic bus_error_n,         // Bus error
  input wire logic power_on_reset_n,    // Reset line
  input wire logic bus_request_n,       // Fixed request
  input wire logic bus_grant_n,         // Fixed grant
  input wire logic acq_run,             // Acquisition running
  input wire logic sync_trigger_a,      // Trigger a
  input wire logic sync_trigger_b,      // Trigger b
  input wire logic convert_gate_a,      // Gate a
  input wire logic convert_gate_b       // Gate b
);
  int low_cnt_reg;
  int low_cnt_next;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Strobe-low length, so the timeout can be bounded without a long repetition
  always_comb low_cnt_next = address_strobe_n ? 0 : low_cnt_reg + 1;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) low_cnt_reg <= 0;
    else low_cnt_reg <= low_cnt_next;
  AST_ARB_FIXED: assert property (bus_request_n && !bus_grant_n)
    else $error("request or grant off its fixed level");
  AST_BYTE_IN_FRAME: assert property (
    !upper_byte_strobe_n || !lower_byte_strobe_n |-> !address_strobe_n)
    else $error("byte strobe outside address strobe");
  AST_WRITE_DRIVE: assert property (data_oe |-> !read_not_write && !address_strobe_n)
    else $error("data driven outside a write");
  AST_DIR_STEADY: assert property (
    !address_strobe_n && !$past(address_strobe_n) |-> $stable(read_not_write))
    else $error("direction changed inside a cycle");
  AST_END_ON_ACK: assert property ($rose(address_strobe_n) |-> cpu_done)
    else $error("cycle ended without completion");
  AST_BERR_AT_TIMEOUT: assert property (
    $fell(bus_error_n) |-> cpu_done && cpu_berr && low_cnt_reg >= BERR_CYCLES - 4)
    else $error("bus error at wrong time");
  AST_BERR_BOUND: assert property (low_cnt_reg <= BERR_CYCLES + 4)
    else $error("cycle outlived the timeout");
  AST_ACK_CLEARS: assert property (cpu_done && !cpu_berr |-> bus_error_n)
    else $error("bus error on acknowledged cycle");
  AST_POR_LOST: assert property (!supply_good |-> ##[1:5] !power_on_reset_n)
    else $error("reset line not low after supply loss");
  AST_TRIG_PAIR: assert property (sync_trigger_a == sync_trigger_b)
    else $error("trigger lines differ");
  AST_GATE_RUN: assert property (!acq_run |=> !convert_gate_a && !convert_gate_b)
    else $error("gate open while stopped");
endmodule
bind backplane_bus_control bus_control_monitor #(.BERR_CYCLES(BERR_CYCLES)) u_mon (
  .clk, .rstn, .supply_good, .cpu_done, .cpu_berr, .data_oe, .address_strobe_n,
  .upper_byte_strobe_n, .lower_byte_strobe_n, .read_not_write, .bus_error_n,
  .power_on_reset_n, .bus_request_n, .bus_grant_n, .acq_run, .sync_trigger_a,
  .sync_trigger_b, .convert_gate_a, .convert_gate_b
);

// ---- tb/backplane_slave_model.sv ----
// Behavioural plug-in board answering processor cycles on the backplane
`timescale 1ns/1ps
module backplane_slave_model #(
  parameter logic [3:0] SLOT = 4'h3
) (
  input  wire logic        clk,                 // Clock
  input  wire logic        rstn,                // Reset, active low
  input  wire logic [21:0] address,             // Backplane address
  input  wire logic [15:0] bus,                 // Resolved data lines
  input  wire logic        address_strobe_n,    // Address strobe
  input  wire logic        upper_byte_strobe_n, // High byte strobe
  input  wire logic        lower_byte_strobe_n, // Low byte strobe
  input  wire logic        read_not_write,      // Direction
  input  wire logic [3:0]  ack_delay,           // Cycles before answering
  output logic             transfer_ack_n,      // Open-collector ack
  output logic             drive_en,            // Driving data lines
  output logic [15:0]      drive_data           // Read data, ones on idle lanes
);
  logic [15:0] mem [16];
  logic [3:0]  wait_cnt;
  logic        sel;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  assign sel = !address_strobe_n && address[21:18] == SLOT;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= 4'h0;
      transfer_ack_n <= 1'b1;
      drive_en <= 1'b0;
      drive_data <= 16'hffff;
    end else if (sel) begin
      if (wait_cnt == ack_delay) begin
        drive_en <= read_not_write;
        drive_data <= {upper_byte_strobe_n ? 8'hff : mem[address[3:0]][15:8],
                       lower_byte_strobe_n ? 8'hff : mem[address[3:0]][7:0]};
        if (!read_not_write && !upper_byte_strobe_n) mem[address[3:0]][15:8] <= bus[15:8];
        if (!read_not_write && !lower_byte_strobe_n) mem[address[3:0]][7:0] <= bus[7:0];
        transfer_ack_n <= 1'b0;
      end
      if (wait_cnt != 4'hf) wait_cnt <= wait_cnt + 4'h1;
    end else begin
      wait_cnt <= 4'h0;
      transfer_ack_n <= 1'b1;
      drive_en <= 1'b0;
    end
  end
endmodule

// ---- tb/backplane_bus_control_tb.sv ----
// Self-checking bench for the backplane bus control block
`timescale 1ns/1ps
module backplane_bus_control_tb;
  localparam int         POR_N = 20;
  localparam logic [3:0] SLOT  = 4'h3;
  logic clk, rstn, supply_good, clock_src, cpu_req, cpu_rnw, acq_run, gate_req_a;
  logic gate_req_b, trigger_event, cpu_busy, cpu_done, cpu_berr, data_oe, slv_en;
  logic address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, read_not_write;
  logic transfer_ack_n, bus_error_n, power_on_reset_n, bus_request_n, bus_grant_n;
  logic acq_master_clock, sync_trigger_a, sync_trigger_b, sample_mem_clock_a;
  logic sample_mem_clock_b, convert_gate_a, convert_gate_b, trigger_enable_line;
  logic                             op_berr, act, m_ten;
  logic [1:0]                       cpu_byte_en, be;
  logic [3:0]                       proc_clocks, ack_dly, prev, p;
  logic [15:0]                      cpu_wdata, cpu_rdata, data_out, data_in, slv_q;
  logic [15:0]                      op_rd, exp_rd;
  logic [15:0]                      exp_mem [16];
  logic [backplane_pkg::ADDR_W-1:0] cpu_addr, address;
  logic [31:0]                      r;
  int                               error_cnt, checks_done, seed, n, cyc, m_sm, m_sm_cnt, acq_hi;
  int                               cnt [4];
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Source runs free and unrelated in phase to clk
  initial begin
    clock_src = 1'b0;
    #137;
    forever #400 clock_src = ~clock_src;
  end
  // Pull-ups on the data lines: undriven lanes read as ones
  assign data_in = data_oe ? data_out : (slv_en ? slv_q : 16'hffff);
  backplane_bus_control #(.POR_CYCLES(POR_N), .BERR_CYCLES(20)) uut (
    .clk, .rstn, .supply_good, .clock_src, .cpu_req, .cpu_rnw, .cpu_byte_en, .cpu_addr,
    .cpu_wdata, .cpu_busy, .cpu_done, .cpu_berr, .cpu_rdata, .address, .data_out,
    .data_oe, .data_in, .address_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n,
    .read_not_write, .transfer_ack_n, .bus_error_n, .power_on_reset_n, .bus_request_n,
    .bus_grant_n, .proc_clocks, .acq_run, .gate_req_a, .gate_req_b, .trigger_event,
    .acq_master_clock, .sync_trigger_a, .sync_trigger_b, .sample_mem_clock_a,
    .sample_mem_clock_b, .convert_gate_a, .convert_gate_b, .trigger_enable_line
  );
  backplane_slave_model #(.SLOT(SLOT)) slave (
    .clk, .rstn, .address, .bus(data_in), .address_strobe_n, .upper_byte_strobe_n,
    .lower_byte_strobe_n, .read_not_write, .ack_delay(ack_dly), .transfer_ack_n,
    .drive_en(slv_en), .drive_data(slv_q)
  );
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bus_op(input logic rnw, input logic [1:0] bn, input logic [21:0] a,
                        input logic [15:0] wd);
    int k;
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_rnw <= rnw;
    cpu_byte_en <= bn;
    cpu_addr <= a;
    cpu_wdata <= wd;
    @(posedge clk);
    cpu_req <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (cpu_done !== 1'b1 && k < 100);
    op_rd = cpu_rdata;
    op_berr = cpu_berr;
    check(16'(k < 100), 16'h1);
    k = 0;
    while (cpu_busy !== 1'b0 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(16'(cpu_busy), 16'h0);
  endtask
  // Counts edges until the reset line rises; any strobe meanwhile is flagged
  task automatic wait_por;
    n = 0;
    act = 1'b0;
    while (power_on_reset_n !== 1'b1 && n < 100) begin
      @(posedge clk);
      if (n == 5) cpu_req <= 1'b0;
      #1;
      act = act | !address_strobe_n;
      n++;
    end
    check(16'(n >= POR_N && n <= POR_N + 8), 16'h1);
    check(16'(act), 16'h0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    seed = 32'h6ea0de23;
    {rstn, supply_good, cpu_req, cpu_rnw, acq_run, gate_req_a, gate_req_b} = 7'h00;
    {trigger_event, m_ten, cpu_byte_en, ack_dly} = 8'h00;
    cpu_addr = '0;
    cpu_wdata = 16'h0000;
    foreach (exp_mem[i]) exp_mem[i] = 16'h0000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    supply_good <= 1'b1;
    cpu_req <= 1'b1;
    wait_por();
    check(16'({bus_request_n, bus_grant_n}), 16'h2);
    @(posedge clk);
    supply_good <= 1'b0;
    repeat (6) @(posedge clk);
    supply_good <= 1'b1;
    #1;
    check(16'(power_on_reset_n), 16'h0);
    wait_por();
    $display("reset line test done");
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      ack_dly <= {1'b0, r[2:0]};
      be = (r[5:4] == 2'b00) ? 2'b11 : r[5:4];
      bus_op(r[3], be, {SLOT, r[23:10], r[9:6]}, r[31:16]);
      exp_rd = {be[1] ? exp_mem[r[9:6]][15:8] : 8'hff, be[0] ? exp_mem[r[9:6]][7:0] : 8'hff};
      if (r[3]) check(op_rd, exp_rd);
      if (!r[3] && be[1]) exp_mem[r[9:6]][15:8] = r[31:24];
      if (!r[3] && be[0]) exp_mem[r[9:6]][7:0] = r[23:16];
      check(16'(op_berr), 16'h0);
    end
    for (int i = 0; i < 2; i++) begin
      bus_op(i[0], 2'b11, {SLOT + 4'h1, 18'h00005}, 16'ha55a);
      check(16'(op_berr), 16'h1);
      bus_op(1'b1, 2'b11, {SLOT, 18'h00005}, 16'h0000);
      check(16'(op_berr), 16'h0);
      check(op_rd, exp_mem[5]);
    end
    $display("bus cycle test done");
    cnt = '{default: 0};
    prev = proc_clocks;
    repeat (800) begin
      @(posedge clk);
      #1;
      for (int k = 0; k < 4; k++) if (proc_clocks[k] && !prev[k]) cnt[k]++;
      prev = proc_clocks;
      acq_hi += acq_master_clock;
    end
    check(16'(cnt[0] >= 99 && cnt[0] <= 101), 16'h1);
    for (int k = 1; k < 4; k++)
      check(16'((cnt[k-1] - 2 * cnt[k]) inside {[-2:2]}), 16'h1);
    // Half of 800 samples high: 50 percent duty
    check(16'(acq_hi), 16'h0190);
    check(16'(sample_mem_clock_a), 16'h0);
    $display("processor clock test done");
    repeat (100) begin
      @(posedge clk);
      p = {acq_run, gate_req_a, gate_req_b, trigger_event};
      r = $random(seed);
      // Running is favoured so that the sample clock divider gets to wrap
      {acq_run, gate_req_a, gate_req_b, trigger_event} <= {r[3] | r[7], r[2:0]};
      #1;
      if (!p[3]) begin
        m_sm = 0;
        m_sm_cnt = 0;
      end else if (m_sm_cnt == backplane_pkg::SMCLK_DIV_DEFAULT - 1) begin
        m_sm = 1 - m_sm;
        m_sm_cnt = 0;
      end else begin
        m_sm_cnt++;
      end
      check({12'h0, convert_gate_a, convert_gate_b, trigger_enable_line, sync_trigger_a},
            {12'h0, p[3] & p[2], p[3] & p[1], p[3], p[0] & m_ten});
      check(16'(sample_mem_clock_a), 16'(m_sm));
      check(16'(sample_mem_clock_b), 16'(m_sm));
      m_ten = p[3];
    end
    $display("acquisition line test done");
    conclude();
  end
endmodule
